// ==== hw/gpcb_defs.svh ====
// register offsets, field positions and reset values of the pin bank
`ifndef GPCB_DEFS_SVH
`define GPCB_DEFS_SVH

`define GPCB_IDX_P1_B1   6'h24
`define GPCB_IDX_P1_B2   6'h25
`define GPCB_IDX_P1_B3   6'h26
`define GPCB_IDX_P1_B4   6'h27
`define GPCB_IDX_P1_B5   6'h28
`define GPCB_IDX_P1_B6   6'h29
`define GPCB_IDX_P1_B7   6'h2a
`define GPCB_IDX_P2_B0   6'h2b
`define GPCB_IDX_DATA    6'h30

`define GPCB_BIT_DIR     0
`define GPCB_BIT_POL     1
`define GPCB_BIT_ALT     2
`define GPCB_BIT_ALT_HI  3
`define GPCB_BIT_OTYPE   7

`define GPCB_CFG_RESET   8'h01
`define GPCB_DATA_RESET  8'h00
`define GPCB_MASK_P1     8'h87
`define GPCB_MASK_P2     8'h8f

`define GPCB_P2_GPIO     2'h0
`define GPCB_P2_KBC      2'h1
`define GPCB_P2_FDS      2'h2
`define GPCB_P2_RSVD     2'h3

`endif

// ==== hw/gpcb_pkg.sv ====
// types shared by the pin bank modules
package gpcb_pkg;
    typedef logic [7:0] gpcb_byte_t;
    typedef enum logic [2:0] {
        GPCB_FN_GPIO,
        GPCB_FN_ALT_IN,
        GPCB_FN_ALT_OUT,
        GPCB_FN_ALT_BIDIR,
        GPCB_FN_OFF
    } gpcb_func_t;
endpackage : gpcb_pkg

// ==== hw/gpcb_pin.sv ====
// one pad cell: input synchroniser and registered driver
`timescale 1ns/1ps
`default_nettype none
module gpcb_pin (
    input  wire logic clock_in,
    input  wire logic reset_n_in,
    input  wire logic pad_in,
    input  wire logic drive_en_in,
    input  wire logic drive_val_in,
    input  wire logic open_drain_in,
    output logic      level_out,
    output logic      pad_out,
    output logic      pad_oe_out
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic pad_out;
        logic pad_oe;
    } gpcb_pin_state_t;

    gpcb_pin_state_t state_reg;
    gpcb_pin_state_t state_next;

    always_comb begin
        state_next       = state_reg;
        state_next.sync1 = pad_in;
        state_next.sync2 = state_reg.sync1;
        if (open_drain_in) begin
            // open drain only ever pulls low
            state_next.pad_out = 1'b0;
            state_next.pad_oe  = drive_en_in & ~drive_val_in;
        end else begin
            state_next.pad_out = drive_val_in;
            state_next.pad_oe  = drive_en_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign level_out  = state_reg.sync2;
    assign pad_out    = state_reg.pad_out;
    assign pad_oe_out = state_reg.pad_oe;
endmodule : gpcb_pin
`default_nettype wire

// ==== hw/gpcb_bank.sv ====
// apb register bank and function routing for eight configurable pins
`timescale 1ns/1ps
`default_nettype none
`include "gpcb_defs.svh"
// Contract
// - config bit 0 sets direction: one input, zero output
// - config bit 1 inverts the pin's logical value when one
// - config bit 7 picks open drain when one, push pull when zero
// - port 1 bit 2 picks game function over gpio; bits 6 to 3 reserved
// - pin at 24h in alternate mode is joystick one button two
// - pin at 25h in alternate mode is joystick two button one
// - pin at 26h in alternate mode is joystick two button two
// - pin at 27h in alternate mode is joystick one x axis input
// - pin at 28h in alternate mode is joystick one y axis input
// - pin at 29h in alternate mode is joystick two x axis input
// - pin at 2ah in alternate mode is joystick two y axis input
// - port 2 bit 0 uses bits 3:2 as function; 00 gpio, 11 reserved
// - port 2 bit 0 code 10 drives second floppy drive select
// - port 2 bit 0 code 01 carries keyboard controller port 1 bit 7
module gpcb_bank #(
    parameter int ADDR_W   = 8,
    parameter int NUM_PINS = 8
) (
    input  wire logic                 clock_in,
    input  wire logic                 reset_n_in,
    input  wire logic                 psel_in,
    input  wire logic                 penable_in,
    input  wire logic                 pwrite_in,
    input  wire logic [ADDR_W-1:0]    paddr_in,
    input  wire logic [31:0]          pwdata_in,
    input  wire logic [3:0]           pstrb_in,
    output logic      [31:0]          prdata_out,
    output logic                      pready_out,
    output logic                      pslverr_out,
    input  wire logic [NUM_PINS-1:0]  pin_in,
    output logic      [NUM_PINS-1:0]  pin_out,
    output logic      [NUM_PINS-1:0]  pin_oe_out,
    input  wire logic                 floppy_drive_select_1_n_in,
    input  wire logic                 kbc_port1_bit7_in,
    output logic                      kbc_port1_bit7_out,
    output logic                      joy1_button2_out,
    output logic                      joy2_button1_out,
    output logic                      joy2_button2_out,
    output logic                      joy1_x_axis_out,
    output logic                      joy1_y_axis_out,
    output logic                      joy2_x_axis_out,
    output logic                      joy2_y_axis_out
);
    import gpcb_pkg::*;

    // eight pins: index 0..6 are port 1 bits 1..7, index 7 is port 2 bit 0
    if (NUM_PINS != 8) begin : g_bad_pins
        $error("gpcb_bank serves exactly eight pins");
    end
    if (ADDR_W < 8) begin : g_bad_addr
        $error("gpcb_bank needs at least eight address bits");
    end

    localparam int P2 = 7;

    typedef struct packed {
        gpcb_byte_t [NUM_PINS-1:0] cfg;
        gpcb_byte_t                data;
        logic [31:0]               prdata;
        logic                      pready;
        logic                      pslverr;
        logic [6:0]                joy;
        logic                      kbc;
    } gpcb_state_t;

    gpcb_state_t state_reg;
    gpcb_state_t state_next;

    logic [NUM_PINS-1:0] level;
    logic [NUM_PINS-1:0] drive_en;
    logic [NUM_PINS-1:0] drive_val;
    logic [NUM_PINS-1:0] open_drain;
    logic [NUM_PINS-1:0] seen;
    gpcb_func_t          func [NUM_PINS];

    genvar gi;
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
        gpcb_pin u_pin (
            .clock_in      (clock_in),
            .reset_n_in    (reset_n_in),
            .pad_in        (pin_in[gi]),
            .drive_en_in   (drive_en[gi]),
            .drive_val_in  (drive_val[gi]),
            .open_drain_in (open_drain[gi]),
            .level_out     (level[gi]),
            .pad_out       (pin_out[gi]),
            .pad_oe_out    (pin_oe_out[gi])
        );
    end

    // function decode and pad drive
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            func[i]       = GPCB_FN_GPIO;
            drive_en[i]   = 1'b0;
            drive_val[i]  = 1'b0;
            open_drain[i] = state_reg.cfg[i][`GPCB_BIT_OTYPE];
            // polarity applies in every function
            seen[i] = level[i] ^ state_reg.cfg[i][`GPCB_BIT_POL];
            if (i < P2) begin
                if (state_reg.cfg[i][`GPCB_BIT_ALT]) begin
                    func[i] = GPCB_FN_ALT_IN;
                end
            end else begin
                unique case (state_reg.cfg[i][`GPCB_BIT_ALT_HI:
                                              `GPCB_BIT_ALT])
                    `GPCB_P2_GPIO: func[i] = GPCB_FN_GPIO;
                    `GPCB_P2_KBC:  func[i] = GPCB_FN_ALT_BIDIR;
                    `GPCB_P2_FDS:  func[i] = GPCB_FN_ALT_OUT;
                    `GPCB_P2_RSVD: func[i] = GPCB_FN_OFF;
                endcase
            end
            unique case (func[i])
                GPCB_FN_GPIO: begin
                    drive_en[i]  = ~state_reg.cfg[i][`GPCB_BIT_DIR];
                    drive_val[i] = state_reg.data[i] ^
                                   state_reg.cfg[i][`GPCB_BIT_POL];
                end
                GPCB_FN_ALT_OUT: begin
                    drive_en[i]  = 1'b1;
                    drive_val[i] = floppy_drive_select_1_n_in ^
                                   state_reg.cfg[i][`GPCB_BIT_POL];
                end
                GPCB_FN_ALT_BIDIR: begin
                    // driver type follows config bit 7 here as elsewhere; the controller also reads the pin
                    drive_en[i]  = 1'b1;
                    drive_val[i] = kbc_port1_bit7_in ^
                                   state_reg.cfg[i][`GPCB_BIT_POL];
                end
                GPCB_FN_ALT_IN, GPCB_FN_OFF: begin
                    drive_en[i]  = 1'b0;
                    drive_val[i] = 1'b0;
                end
            endcase
        end
    end

    logic [ADDR_W-3:0] word_idx;
    logic              aligned;
    logic              hit_cfg;
    logic              hit_data;
    logic [2:0]        cfg_sel;
    logic [ADDR_W-3:0] cfg_base;
    logic [ADDR_W-3:0] cfg_last;
    logic [ADDR_W-3:0] data_idx;
    gpcb_byte_t        cfg_mask;
    gpcb_byte_t        rd_byte;
    logic              setup;
    logic              access;

    assign word_idx = paddr_in[ADDR_W-1:2];
    assign aligned  = (paddr_in[1:0] == 2'h0);
    assign cfg_base = (ADDR_W-2)'(`GPCB_IDX_P1_B1);
    assign cfg_last = (ADDR_W-2)'(`GPCB_IDX_P2_B0);
    assign data_idx = (ADDR_W-2)'(`GPCB_IDX_DATA);
    assign hit_cfg  = aligned && word_idx >= cfg_base &&
                      word_idx <= cfg_last;
    assign hit_data = aligned && word_idx == data_idx;
    assign cfg_sel  = 3'(word_idx - cfg_base);
    assign cfg_mask = (cfg_sel == 3'(P2)) ? `GPCB_MASK_P2 : `GPCB_MASK_P1;
    assign setup    = psel_in & ~penable_in;
    assign access   = psel_in & penable_in & state_reg.pready;

    // data read: gpio outputs show the stored value, inputs and alternate functions show the pad
    always_comb begin
        rd_byte = 8'h00;
        if (hit_cfg) begin
            rd_byte = state_reg.cfg[cfg_sel];
        end else if (hit_data) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                if (func[i] == GPCB_FN_GPIO &&
                    !state_reg.cfg[i][`GPCB_BIT_DIR]) begin
                    rd_byte[i] = state_reg.data[i];
                end else begin
                    rd_byte[i] = seen[i];
                end
            end
        end
    end

    // apb slave and registered outputs
    always_comb begin
        state_next        = state_reg;
        // answer in the first access cycle, no wait states
        state_next.pready = setup;
        if (setup) begin
            state_next.prdata  = pwrite_in ? 32'h0 : {24'h0, rd_byte};
            state_next.pslverr = ~(hit_cfg | hit_data);
        end else if (access) begin
            state_next.prdata  = 32'h0;
            state_next.pslverr = 1'b0;
        end
        if (access && pwrite_in && pstrb_in[0]) begin
            if (hit_cfg) begin
                // reserved bits are dropped so they read back as zero
                state_next.cfg[cfg_sel] = pwdata_in[7:0] & cfg_mask;
            end else if (hit_data) begin
                state_next.data = pwdata_in[7:0];
            end
        end
        // idle level one when a game input is not routed
        state_next.joy = 7'h7f;
        for (int i = 0; i < P2; i++) begin
            if (func[i] == GPCB_FN_ALT_IN) begin
                state_next.joy[i] = seen[i];
            end
        end
        state_next.kbc = (func[P2] == GPCB_FN_ALT_BIDIR) ?
                         seen[P2] : 1'b1;
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                state_reg.cfg[i] <= `GPCB_CFG_RESET;
            end
            state_reg.data    <= `GPCB_DATA_RESET;
            state_reg.prdata  <= 32'h0;
            state_reg.pready  <= 1'b0;
            state_reg.pslverr <= 1'b0;
            state_reg.joy     <= 7'h7f;
            state_reg.kbc     <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata_out         = state_reg.prdata;
    assign pready_out         = state_reg.pready;
    assign pslverr_out        = state_reg.pslverr;
    assign kbc_port1_bit7_out = state_reg.kbc;
    assign joy1_button2_out   = state_reg.joy[0];
    assign joy2_button1_out   = state_reg.joy[1];
    assign joy2_button2_out   = state_reg.joy[2];
    assign joy1_x_axis_out    = state_reg.joy[3];
    assign joy1_y_axis_out    = state_reg.joy[4];
    assign joy2_x_axis_out    = state_reg.joy[5];
    assign joy2_y_axis_out    = state_reg.joy[6];
endmodule : gpcb_bank
`default_nettype wire

// ==== dv/gpcb_bank_props.sv ====
// port checks for the pin bank's bus side and reset state
`timescale 1ns/1ps
`default_nettype none
module gpcb_bank_props (
    input wire logic        clock_in,
    input wire logic        reset_n_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic [7:0]  pin_oe_out,
    input wire logic        joy1_button2_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    a_ready_next: assert property (s_setup |=> pready_out)
        else $error("no ready after setup");
    a_ready_once: assert property (pready_out |=> !pready_out)
        else $error("ready held too long");
    a_ready_idle: assert property (!psel_in |=> !pready_out)
        else $error("ready without request");
    a_err_ready: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    a_err_unalign: assert property
        (s_setup ##0 (paddr_in[1:0] != 2'h0) |=> pslverr_out)
        else $error("unaligned access not refused");
    a_err_unmapped: assert property
        (s_setup ##0 (paddr_in == 8'h00) |=> pslverr_out)
        else $error("unmapped access not refused");
    a_upper_zero: assert property
        (pready_out |-> prdata_out[31:8] == 24'h0)
        else $error("upper read bits set");
    a_write_quiet: assert property
        (pready_out && pwrite_in |-> prdata_out == 32'h0)
        else $error("read data on write");
    // checked through reset itself, so no disable here
    a_reset_state: assert property (disable iff (1'b0)
        !reset_n_in |=> pin_oe_out == 8'h00 && joy1_button2_out)
        else $error("reset state wrong");
endmodule : gpcb_bank_props
`default_nettype wire

// ==== dv/test_gpio_pin_config_bank.sv ====
// self-checking bench for the pin configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "gpcb_defs.svh"
module test_gpio_pin_config_bank;
    logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
    logic [7:0]  paddr = 0, pwd = 0, pin = 0, pout, poe;
    logic [6:0]  joy;
    logic [31:0] prdata;
    logic        prdy, perr, fds = 1, kbc_i = 1, kbc_o;
    int          mismatches = 0, n_checks = 0;
    gpcb_bank #(.ADDR_W(8), .NUM_PINS(8)) uut (
        .clock_in(clk), .reset_n_in(rst_n), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in({24'h0, pwd}), .pstrb_in(4'h1), .prdata_out(prdata),
        .pready_out(prdy), .pslverr_out(perr), .pin_in(pin),
        .pin_out(pout), .pin_oe_out(poe),
        .floppy_drive_select_1_n_in(fds), .kbc_port1_bit7_in(kbc_i),
        .kbc_port1_bit7_out(kbc_o), .joy1_button2_out(joy[0]),
        .joy2_button1_out(joy[1]), .joy2_button2_out(joy[2]),
        .joy1_x_axis_out(joy[3]), .joy1_y_axis_out(joy[4]),
        .joy2_x_axis_out(joy[5]), .joy2_y_axis_out(joy[6]));
    initial forever #50 clk = ~clk;
    function automatic logic [7:0] ba(input logic [5:0] i);
        return {i, 2'b00};
    endfunction : ba
    task automatic chk(input string nm, input logic [31:0] x, g);
        n_checks++;
        if (g !== x) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic end_of_test;
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test
    task automatic apb(input logic w, input logic [7:0] a, d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 20);
        if (n >= 20) mismatches++;
        r = prdata;
        e = perr;
        psel <= 0;
        pen <= 0;
    endtask : apb
    task automatic wr(input logic [7:0] a, d);
        logic [31:0] r;
        logic        e;
        apb(1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input logic xe);
        logic [31:0] r;
        logic        e;
        apb(0, a, 8'h00, r, e);
        chk("prdata", x, r);
        chk("pslverr", {31'h0, xe}, {31'h0, e});
    endtask : rd
    // pads pass two sync flops, so four edges is always enough
    task automatic settle;
        repeat (4) @(posedge clk);
    endtask : settle
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        end_of_test;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1;
        for (int i = 0; i < 8; i++)
            rd(ba(6'(`GPCB_IDX_P1_B1 + i)), 32'h01, 0);
        wr(ba(`GPCB_IDX_P1_B3), 8'hff);
        rd(ba(`GPCB_IDX_P1_B3), 32'h87, 0);
        wr(ba(`GPCB_IDX_P1_B3), 8'h01);
        wr(ba(`GPCB_IDX_P2_B0), 8'hf1);
        rd(ba(`GPCB_IDX_P2_B0), 32'h81, 0);
        rd(8'h00, 32'h0, 1);
        rd(8'h91, 32'h0, 1);
        wr(ba(`GPCB_IDX_P1_B1), 8'h00);
        wr(ba(`GPCB_IDX_DATA), 8'h01);
        settle();
        chk("pin_out", 1, pout[0]);
        chk("pin_oe", 1, poe[0]);
        rd(ba(`GPCB_IDX_DATA), 32'h01, 0);
        wr(ba(`GPCB_IDX_P1_B1), 8'h02);
        settle();
        chk("pin_out", 0, pout[0]);
        wr(ba(`GPCB_IDX_P1_B1), 8'h80);
        settle();
        chk("pin_oe", 0, poe[0]);
        wr(ba(`GPCB_IDX_DATA), 8'h00);
        settle();
        chk("pin_oe", 1, poe[0]);
        chk("pin_out", 0, pout[0]);
        wr(ba(`GPCB_IDX_P1_B1), 8'h01);
        wr(ba(`GPCB_IDX_P1_B2), 8'h03);
        pin <= 8'h5a;
        settle();
        rd(ba(`GPCB_IDX_DATA), 32'h58, 0);
        chk("joy", 7'h7f, joy);
        for (int i = 0; i < 7; i++)
            wr(ba(6'(`GPCB_IDX_P1_B1 + i)), 8'h05);
        pin <= 8'h35;
        settle();
        chk("joy", 7'h35, joy);
        pin <= 8'h4a;
        settle();
        chk("joy", 7'h4a, joy);
        wr(ba(`GPCB_IDX_P2_B0), 8'h08);
        fds <= 0;
        settle();
        chk("pin_out", 0, pout[7]);
        chk("pin_oe", 1, poe[7]);
        fds <= 1;
        settle();
        chk("pin_out", 1, pout[7]);
        wr(ba(`GPCB_IDX_P2_B0), 8'h05);
        pin <= 8'h80;
        settle();
        chk("kbc", 1, kbc_o);
        pin <= 8'h00;
        settle();
        chk("kbc", 0, kbc_o);
        chk("pin_oe", 1, poe[7]);
        chk("pin_out", 1, pout[7]);
        kbc_i <= 0;
        settle();
        chk("pin_out", 0, pout[7]);
        kbc_i <= 1;
        settle();
        chk("pin_out", 1, pout[7]);
        wr(ba(`GPCB_IDX_P2_B0), 8'h0c);
        settle();
        chk("pin_oe", 0, poe[7]);
        end_of_test;
    end
endmodule : test_gpio_pin_config_bank
bind gpcb_bank gpcb_bank_props u_props (
    .clock_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .prdata_out, .pready_out, .pslverr_out, .pin_oe_out,
    .joy1_button2_out);
`default_nettype wire
